// ### dpc_pkg.sv
// Purpose: shared constants and types for the two-wire potentiometer control block
// Assumes: all users import dpc_pkg::*
// Notes:   bit positions refer to the instruction byte
package dpc_pkg;
    // ********************
    // protocol constants
    // ********************
    localparam logic [4:0] ADDR_FIXED = 5'h0b;  // fixed upper address bits
    localparam logic [3:0] BYTE_BITS  = 4'h8;   // data bits in one byte
    localparam logic [7:0] MIDSCALE   = 8'h80;  // centre tap code
    localparam logic [7:0] CODE_ZERO  = 8'h00;  // wiper at terminal b
    localparam int unsigned IB_CHAN   = 7;      // channel select bit
    localparam int unsigned IB_MIDRST = 6;      // midscale reset bit
    localparam int unsigned IB_SHUT   = 5;      // shutdown bit
    localparam int unsigned IB_OUT2   = 4;      // second logic output
    localparam int unsigned IB_OUT1   = 3;      // first logic output
    localparam int unsigned SYNC_W    = 5;      // synchronised pin count

    // ********************
    // protocol states
    // ********************
    typedef enum logic [9:0] {
        ST_IDLE   = 10'h001,  // waiting for start
        ST_ADDR   = 10'h002,  // shifting address byte
        ST_AACK   = 10'h004,  // driving address ack
        ST_INSTR  = 10'h008,  // shifting instruction byte
        ST_IACK   = 10'h010,  // driving instruction ack
        ST_WDATA  = 10'h020,  // shifting data byte
        ST_WACK   = 10'h040,  // driving data ack
        ST_RDATA  = 10'h080,  // sending wiper code
        ST_RACK   = 10'h100,  // sampling master ack
        ST_IGNORE = 10'h200   // deaf until next start
    } dpc_fsm_t;
endpackage

// ### dpc_sync.sv
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: each bit is an independent level
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module dpc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pin_raw,
    output logic      [W-1:0] pin_sync
);
    // ********************
    // state
    // ********************
    typedef struct packed {
        logic [W-1:0] s1;  // metastable stage, read by s2 only
        logic [W-1:0] s2;  // settled stage
    } dpc_sync_t;

    dpc_sync_t q;  // registered state
    dpc_sync_t d;  // next state

    // shift the raw level through both stages
    always_comb begin
        d    = q;
        d.s1 = pin_raw;
        d.s2 = q.s1;
    end

    // reset to all ones: idle bus and inactive pins read high
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign pin_sync = q.s2;
endmodule

// ### dpc_core.sv
// Purpose: two-wire slave that programs two wiper latches and logic outputs
// Assumes: scl and sda are slow against clk_sys (scl period 48 ns or more)
// Notes:   sda is open drain; sda_out is always low and sda_oe pulls it
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - each channel holds 8-bit wiper code
// RL2 - address is 01011 then two strap bits
// RL3 - master opens transfers with start
// RL4 - ack address on ninth pulse if matched
// RL5 - rw one reads, zero writes
// RL6 - write carries instruction byte after address
// RL7 - instruction bit 7 picks channel
// RL8 - instruction bit 6 recentres selected wiper
// RL9 - instruction bit 5 enters shutdown
// RL10 - shutdown pin acts same, active low
// RL11 - bits 4,3 latch onto logic outputs
// RL12 - data byte after instruction sets wiper
// RL13 - nine pulses per byte, msb first
// RL14 - sda changes only while scl low
// RL15 - read sends wiper code right after ack
// RL16 - master closes transfers with stop
// RL17 - write stop raised on tenth pulse
// RL18 - read stop follows master no-ack
// RL19 - every acked data byte loads latch
// RL20 - new instruction needs new transfer
// RL21 - repeated reads resend selected code
// RL22 - read returns last selected channel
// RL23 - power-on presets latches to midscale
// RL24 - logic outputs reset to zero
// RL25 - shutdown keeps latches, restores after
// RL26 - midscale code is 0x80
// RL27 - mismatch ignores bus until next start
module dpc_core
    import dpc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       addr_strap_low,
    input  wire logic       addr_strap_high,
    input  wire logic       shutdown_pin_n,
    output logic [7:0]      wiper_latch_ch1,
    output logic [7:0]      wiper_latch_ch2,
    output logic [7:0]      wiper_tap_ch1,
    output logic [7:0]      wiper_tap_ch2,
    output logic            term_a_open,
    output logic            logic_output_first,
    output logic            logic_output_second
);
    // ********************
    // state
    // ********************
    typedef struct packed {
        dpc_fsm_t   fsm;       // protocol state
        logic       scl_q;     // scl one cycle ago
        logic       sda_q;     // sda one cycle ago
        logic [7:0] shreg;     // receive or transmit byte
        logic [3:0] cnt;       // bits seen in this byte
        logic       rw;        // direction of transfer
        logic       chan_sel;  // last selected channel
        logic [7:0] latch1;    // wiper code channel one
        logic [7:0] latch2;    // wiper code channel two
        logic       shut_bit;  // shutdown from instruction
        logic       lo1;       // first logic output
        logic       lo2;       // second logic output
        logic       sda_oe;    // pulling sda low
        logic       sda_out;   // open-drain level, fixed low
        logic       t_open;    // terminal a open
        logic [7:0] tap1;      // applied code channel one
        logic [7:0] tap2;      // applied code channel two
    } dpc_regs_t;

    dpc_regs_t          q;      // registered state
    dpc_regs_t          d;      // next state
    logic [SYNC_W-1:0]  pins;   // synchronised pins
    logic               scl_s;  // settled scl
    logic               sda_s;  // settled sda
    logic               adr_lo_s; // settled low strap
    logic               adr_hi_s; // settled high strap
    logic               shut_n_s; // settled shutdown pin, low active
    logic               scl_rise;
    logic               scl_fall;
    logic               start;
    logic               stop;
    logic               byte_done;
    logic [7:0]         sel_code;

    // ********************
    // pin synchronisers
    // ********************
    dpc_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .pin_raw  ({shutdown_pin_n, addr_strap_high, addr_strap_low, sda_in, scl_in}),
        .pin_sync (pins)
    );

    assign {shut_n_s, adr_hi_s, adr_lo_s, sda_s, scl_s} = pins;

    // ********************
    // bus events
    // ********************
    // edges are taken on the settled copies; both wires see equal delay
    assign scl_rise  = scl_s & ~q.scl_q;
    assign scl_fall  = ~scl_s & q.scl_q;
    assign start     = scl_s & q.scl_q & q.sda_q & ~sda_s;
    assign stop      = scl_s & q.scl_q & ~q.sda_q & sda_s;
    assign byte_done = scl_fall && (q.cnt == BYTE_BITS);
    assign sel_code  = pick(q.chan_sel, q.latch1, q.latch2); // RL22

    // pick a channel's stored code
    function automatic logic [7:0] pick(input logic sel,
                                        input logic [7:0] c1,
                                        input logic [7:0] c2);
        pick = sel ? c2 : c1;
    endfunction

    // ********************
    // next-state logic
    // ********************
    // sda is only ever changed after an scl fall, so the device never
    // makes a false start or stop of its own
    always_comb begin
        d         = q;
        d.scl_q   = scl_s;
        d.sda_q   = sda_s;
        d.sda_out = 1'b0;
        if (start) begin
            // a start resynchronises from any state, even ignore
            d.fsm    = ST_ADDR; // RL3 RL27
            d.cnt    = '0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.fsm    = ST_IDLE; // RL16
            d.sda_oe = 1'b0;
        end else begin
            case (q.fsm)
                ST_ADDR, ST_INSTR, ST_WDATA: begin
                    // receive bits msb first on each rise
                    if (scl_rise) begin
                        d.shreg = {q.shreg[6:0], sda_s}; // RL13
                        d.cnt   = q.cnt + 4'h1;
                    end
                    if (byte_done) begin
                        d.cnt    = '0;
                        d.sda_oe = 1'b1; // RL4
                        if (q.fsm == ST_ADDR) begin
                            if (q.shreg[7:1] == {ADDR_FIXED, adr_hi_s, adr_lo_s}) begin // RL2
                                d.fsm = ST_AACK;
                                d.rw  = q.shreg[0]; // RL5
                            end else begin
                                // stay off the bus for a stranger
                                d.fsm    = ST_IGNORE; // RL27
                                d.sda_oe = 1'b0;
                            end
                        end else if (q.fsm == ST_INSTR) begin
                            d.fsm      = ST_IACK;
                            d.chan_sel = q.shreg[IB_CHAN]; // RL7
                            d.shut_bit = q.shreg[IB_SHUT]; // RL9
                            d.lo2      = q.shreg[IB_OUT2]; // RL11
                            d.lo1      = q.shreg[IB_OUT1]; // RL11
                            if (q.shreg[IB_MIDRST]) begin
                                if (q.shreg[IB_CHAN]) begin
                                    d.latch2 = MIDSCALE; // RL8 RL26
                                end else begin
                                    d.latch1 = MIDSCALE; // RL8 RL26
                                end
                            end
                        end else begin
                            // each acked data byte lands in the latch
                            d.fsm = ST_WACK;
                            if (q.chan_sel) begin
                                d.latch2 = q.shreg; // RL12 RL19
                            end else begin
                                d.latch1 = q.shreg; // RL12 RL19
                            end
                        end
                    end
                end
                ST_AACK: begin
                    // release the ack on the ninth fall
                    if (scl_fall) begin
                        d.cnt = '0;
                        if (q.rw) begin
                            d.fsm    = ST_RDATA; // RL15
                            d.shreg  = sel_code;
                            d.sda_oe = ~sel_code[7]; // RL14
                        end else begin
                            d.fsm    = ST_INSTR; // RL6
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                ST_IACK, ST_WACK: begin
                    // further bytes are data, never a new instruction
                    if (scl_fall) begin
                        d.fsm    = ST_WDATA; // RL20
                        d.cnt    = '0;
                        d.sda_oe = 1'b0;
                    end
                end
                ST_RDATA: begin
                    // count rises, move to next bit on each fall
                    if (scl_rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end
                    if (byte_done) begin
                        d.fsm    = ST_RACK;
                        d.sda_oe = 1'b0;
                    end else if (scl_fall) begin
                        d.shreg  = {q.shreg[6:0], 1'b0};
                        d.sda_oe = ~q.shreg[6]; // RL14
                    end
                end
                ST_RACK: begin
                    // low on the ninth rise asks for another byte
                    if (scl_rise) begin
                        d.rw = ~sda_s;
                    end
                    if (scl_fall) begin
                        d.cnt = '0;
                        if (q.rw) begin
                            d.fsm    = ST_RDATA; // RL21
                            d.shreg  = sel_code;
                            d.sda_oe = ~sel_code[7];
                        end else begin
                            d.fsm = ST_IGNORE; // RL18
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    d.sda_oe = 1'b0;
                end
                default: begin
                    d.fsm    = ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
        // applied codes: shutdown parks the wiper, latches stay intact
        d.t_open = d.shut_bit | ~shut_n_s; // RL9 RL10
        d.tap1   = d.t_open ? CODE_ZERO : d.latch1; // RL1 RL25
        d.tap2   = d.t_open ? CODE_ZERO : d.latch2; // RL25
    end

    // ********************
    // registers
    // ********************
    // power-on preset: midscale wipers, outputs low
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q          <= '0;
            q.fsm      <= ST_IDLE;
            q.scl_q    <= 1'b1;
            q.sda_q    <= 1'b1;
            q.latch1   <= MIDSCALE; // RL23 RL26
            q.latch2   <= MIDSCALE; // RL23 RL26
            q.tap1     <= MIDSCALE;
            q.tap2     <= MIDSCALE;
        end else begin
            q <= d;
        end
    end

    assign sda_out             = q.sda_out;
    assign sda_oe              = q.sda_oe;
    assign wiper_latch_ch1     = q.latch1;
    assign wiper_latch_ch2     = q.latch2;
    assign wiper_tap_ch1       = q.tap1;
    assign wiper_tap_ch2       = q.tap2;
    assign term_a_open         = q.t_open;
    assign logic_output_first  = q.lo1; // RL24
    assign logic_output_second = q.lo2; // RL24

    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_addr_done;
        !start && !stop && q.fsm == ST_ADDR && byte_done;
    endsequence

    sequence s_instr_done;
        !start && !stop && q.fsm == ST_INSTR && byte_done;
    endsequence

    a_addr_ack: assert property ( // RL4
        s_addr_done ##0 (q.shreg[7:1] == {ADDR_FIXED, adr_hi_s, adr_lo_s})
        |=> sda_oe && q.fsm == ST_AACK)
        else $error("matched address not acked");

    a_mismatch_quiet: assert property ( // RL27
        q.fsm == ST_IGNORE |-> !sda_oe)
        else $error("sda driven while ignoring");

    a_sda_moves_low: assert property ( // RL14
        $changed(sda_oe) |-> $past(scl_fall || start || stop))
        else $error("sda changed while scl high");

    a_midscale_load: assert property ( // RL8
        s_instr_done ##0 q.shreg[IB_MIDRST] && !q.shreg[IB_CHAN]
        |=> wiper_latch_ch1 == MIDSCALE ##1 wiper_tap_ch1 == MIDSCALE || term_a_open)
        else $error("midscale not applied");

    a_outs_latched: assert property ( // RL11
        s_instr_done |=> logic_output_second == $past(q.shreg[IB_OUT2])
        && logic_output_first == $past(q.shreg[IB_OUT1]))
        else $error("logic outputs not latched");

    a_reset_preset: assert property ( // RL23
        $past(sys_rst) |-> wiper_latch_ch1 == MIDSCALE
        && wiper_latch_ch2 == MIDSCALE && !logic_output_first && !logic_output_second)
        else $error("power-on preset wrong");

    a_data_load: assert property ( // RL19
        !start && !stop && q.fsm == ST_WDATA && byte_done
        |=> pick(q.chan_sel, wiper_latch_ch1, wiper_latch_ch2) == $past(q.shreg))
        else $error("data byte not loaded");

    a_read_first: assert property ( // RL15
        !start && !stop && q.fsm == ST_AACK && scl_fall && q.rw
        |=> sda_oe == ~$past(sel_code[7]) && q.fsm == ST_RDATA)
        else $error("read did not start");

    a_write_path: assert property ( // RL6
        !start && !stop && q.fsm == ST_AACK && scl_fall && !q.rw
        |=> q.fsm == ST_INSTR && !sda_oe)
        else $error("write skipped instruction");

    a_shutdown_park: assert property ( // RL10
        !shut_n_s |-> ##1 term_a_open && wiper_tap_ch1 == CODE_ZERO)
        else $error("shutdown pin ignored");

    a_latch_kept: assert property ( // RL25
        term_a_open && $stable(q.fsm) |=> $stable(wiper_latch_ch1)
        || $past(byte_done))
        else $error("latch lost in shutdown");
endmodule

// ### dpc_bus_master.sv
// Purpose: behavioural two-wire bus master that drives the potentiometer slave
// Assumes: sda is open drain and its pull-up is resolved in the bench
// Notes:   scl stands high between transfers; pacing counts clk_sys edges
`timescale 1ns/1ps
module dpc_bus_master (
    input  wire logic clk_sys,   // bench clock, paces every link edge
    input  wire logic sda_line,  // resolved wired level of sda
    output logic      scl_out,   // link clock, idles high
    output logic      sda_pull   // high = master pulls sda low
);
    // ********************
    // link primitives
    // ********************
    // idle bus at time zero
    initial begin
        scl_out  = 1'b1;
        sda_pull = 1'b0;
    end

    // wait n edges, then step just past the edge
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // start or repeated start; sda moves 3 edges after scl falls so the
    // slave's synchroniser never sees it inside the high phase
    task automatic start();
        tk(3);
        sda_pull = 1'b0;
        tk(3);
        scl_out = 1'b1;
        tk(3);
        sda_pull = 1'b1;
        tk(3);
        scl_out = 1'b0;
    endtask

    // stop: sda low first, then rises while scl high
    task automatic stop();
        tk(3);
        sda_pull = 1'b1;
        tk(3);
        scl_out = 1'b1;
        tk(3);
        sda_pull = 1'b0;
        tk(6);
    endtask

    // one clock pulse: drive b in the low phase, sample late in the high phase
    task automatic bit_io(input logic b, output logic r);
        tk(3);
        sda_pull = ~b;
        tk(3);
        scl_out = 1'b1;
        tk(5);
        r = sda_line;
        tk(1);
        scl_out = 1'b0;
    endtask

    // eight bits msb first, then the receiver's ack slot
    task automatic tx_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // read eight bits, then ack to continue or leave sda high to end
    task automatic rx_byte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~give_ack, r);
    endtask
endmodule

// ### dpc_core_tb.sv
// Purpose: self-checking bench for the two-wire potentiometer control core
// Assumes: dpc_bus_master plays the bus master; sda pull-up resolved here
// Notes:   expectations are queued, a watcher pairs them with observations
`timescale 1ns/1ps
module dpc_core_tb
    import dpc_pkg::*;
;
    // ********************
    // signals
    // ********************
    logic       clk_sys;                      // 250 MHz system clock
    logic       sys_rst;                      // synchronous reset
    wire logic  scl_in;                       // link clock from master
    wire logic  sda_in;                       // resolved sda level
    wire logic  m_pull;                       // master pulls sda
    logic       sda_out, sda_oe;              // slave open-drain pair
    logic       addr_strap_low, addr_strap_high, shutdown_pin_n;
    logic [7:0] wiper_latch_ch1, wiper_latch_ch2, wiper_tap_ch1, wiper_tap_ch2;
    logic       term_a_open, logic_output_first, logic_output_second;
    logic [7:0] el [2];                       // expected latches
    logic       ch, sdb, eo1, eo2;            // expected instruction state
    logic [31:0] seed;                        // xorshift state
    logic [7:0] exp_q[$], obs_q[$];           // expectation and observation queues
    logic       watch = 1'b0, oe_seen = 1'b0; // sda drive monitor
    int         err_total = 0, num_checks = 0, cyc = 0;

    // wired-and: either party pulling wins, else the pull-up
    assign sda_in = ~(m_pull | (sda_oe & ~sda_out));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    dpc_core uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
        .addr_strap_high(addr_strap_high), .shutdown_pin_n(shutdown_pin_n),
        .wiper_latch_ch1(wiper_latch_ch1), .wiper_latch_ch2(wiper_latch_ch2),
        .wiper_tap_ch1(wiper_tap_ch1), .wiper_tap_ch2(wiper_tap_ch2),
        .term_a_open(term_a_open), .logic_output_first(logic_output_first),
        .logic_output_second(logic_output_second)
    );

    dpc_bus_master mst (
        .clk_sys(clk_sys), .sda_line(sda_in), .scl_out(scl_in), .sda_pull(m_pull)
    );

    // ********************
    // checking
    // ********************
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        num_checks++;
        if (v !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, v, e);
        end
    endtask

    task automatic note(input logic [7:0] e);
        exp_q.push_back(e);
    endtask

    task automatic post(input logic [7:0] v);
        obs_q.push_back(v);
    endtask

    // pair oldest observation with oldest expectation, off the active edge
    initial begin
        forever begin
            @(negedge clk_sys);
            while (obs_q.size() > 0) chk(obs_q.pop_front(), exp_q.pop_front());
        end
    end

    // the slave must stay off sda while it is not addressed
    always @(posedge clk_sys) if (watch && sda_oe) oe_seen <= 1'b1;

    // hang guard: far above the few thousand cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end

    // ********************
    // transfers
    // ********************
    task automatic state();
        logic off;
        off = sdb | ~shutdown_pin_n;
        note(el[0]);
        post(wiper_latch_ch1);
        note(el[1]);
        post(wiper_latch_ch2);
        note(off ? CODE_ZERO : el[0]);
        post(wiper_tap_ch1);
        note(off ? CODE_ZERO : el[1]);
        post(wiper_tap_ch2);
        note({5'h00, off, eo2, eo1});
        post({5'h00, term_a_open, logic_output_second, logic_output_first});
    endtask

    task automatic addr(input logic rw, input logic [6:0] a, input logic ex);
        logic ak;
        mst.start();
        mst.tx_byte({a, rw}, ak);
        note({7'h00, ex});
        post({7'h00, ak});
    endtask

    task automatic wr(input logic [7:0] ins, input int n, input logic stp);
        logic ak;
        logic [7:0] d;
        addr(1'b0, {ADDR_FIXED, addr_strap_high, addr_strap_low}, 1'b1);
        mst.tx_byte(ins, ak);
        ch = ins[IB_CHAN];
        if (ins[IB_MIDRST]) el[ch] = MIDSCALE;
        sdb = ins[IB_SHUT];
        eo2 = ins[IB_OUT2];
        eo1 = ins[IB_OUT1];
        note(8'h01);
        post({7'h00, ak});
        for (int k = 0; k < n; k++) begin
            d = rnd8();
            mst.tx_byte(d, ak);
            el[ch] = d;
            note(8'h01);
            post({7'h00, ak});
        end
        if (stp) mst.stop();
    endtask

    task automatic rd(input int n);
        logic [7:0] d;
        addr(1'b1, {ADDR_FIXED, addr_strap_high, addr_strap_low}, 1'b1);
        for (int k = 0; k < n; k++) begin
            mst.rx_byte(k < n - 1, d);
            note(el[ch]);
            post(d);
        end
        mst.stop();
    endtask

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        seed = 32'h1a0183db;
        sys_rst = 1'b1;
        {addr_strap_high, addr_strap_low} = 2'(rnd8());
        shutdown_pin_n = 1'b1;
        el[0] = MIDSCALE;
        el[1] = MIDSCALE;
        {ch, sdb, eo1, eo2} = 4'h0;
        repeat (2) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        state();
        tend("reset");
        mst.tk(4);
        wr(8'h10 | {5'h00, 3'(rnd8())}, 2, 1'b1);
        state();
        rd(2);
        tend("write ch1");
        wr(8'h88, 1, 1'b1);
        rd(1);
        wr(8'hc0, 0, 1'b1);
        state();
        rd(1);
        tend("midscale ch2");
        wr(8'h20, 0, 1'b1);
        state();
        rd(1);
        wr(8'h40, 0, 1'b1);
        state();
        tend("shutdown bit");
        shutdown_pin_n = 1'b0;
        mst.tk(8);
        state();
        shutdown_pin_n = 1'b1;
        mst.tk(8);
        state();
        tend("shutdown pin");
        watch = 1'b1;
        for (int i = 0; i < 7; i++) begin
            addr(i[0], {ADDR_FIXED, addr_strap_high, addr_strap_low} ^ (7'h01 << i), 1'b0);
            mst.tx_byte(rnd8(), sdb);
            sdb = 1'b0;
            mst.stop();
        end
        watch = 1'b0;
        note(8'h00);
        post({7'h00, oe_seen});
        tend("mismatch");
        for (int i = 0; i < 4; i++) begin
            {addr_strap_high, addr_strap_low} = i[1:0];
            mst.tk(4);
            addr(1'b0, {ADDR_FIXED, addr_strap_high, addr_strap_low}, 1'b1);
            mst.stop();
        end
        tend("straps");
        wr(8'h98, 1, 1'b0);
        rd(2);
        state();
        tend("repeated start");
        mst.tk(4);
        test_done();
    end
endmodule
